/* pic_consts.svh */
// Constants of the algebraic pulse index coder
// Functional notes
// - Sixty-four positions, four interleaved tracks
// - Four position bits plus sign per track
// - Every pulse has unit amplitude
// - Constellation count table built recursively
// - Partition offset sums lower first-part counts
// - Encoder state recursion down to positions
// - Decoder searches first-part count, splits state
// - Count and state arithmetic wider than 32
// - Merge equal positions, sort ascending
// - Offset index from fixed shared table
// - Position index ranks ascending subsets
// - Count index ranks surplus pulse distribution
// - Sign bit zero positive, one negative
// - Global index combines offset, rank, signs
// - Joint index of two three-pulse tracks
// - Threshold selects 24 or 25 bits
// - Two-pulse tracks indexed separately, sequentially
// - Lower positions, more positions, smaller index
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH
`define TRACK_POS   16
`define ENUM_LAST   4'hF
`define LEN_FOUR    7'h14
`define LEN_DUO     7'h0A
`define LEN_SHORT   7'h18
`define LEN_LONG    7'h19
`define LEN_ENUM    7'h40
`define JOINT_INDEX_THRESHOLD 25'h0371C00
`define OFF_N3      13'h0000
`define OFF_N2      13'h1180
`define OFF_N1      13'h1540
`define TRI_RANGE   13'h1560
`endif

/* pic_pkg.sv */
// Types shared by the pulse index coder and its neighbours
package pic_pkg;
  typedef enum logic [2:0] {
    MODE_FOUR,
    MODE_DUO,
    MODE_TRI_JOINT,
    MODE_ENUM_ENC,
    MODE_ENUM_DEC
  } op_mode_e;

  typedef struct packed {
    op_mode_e             mode;
    logic [3:0][5:0]      pos;
    logic [3:0]           neg;
    logic [1:0][2:0][3:0] tri_pos;
    logic [1:0][2:0]      tri_neg;
    logic [15:0][2:0]     pulse_count_vector;
    logic [15:0]          cnt_neg;
    logic [2:0]           total;
    logic [63:0]          state;
  } pulse_req_s;

  typedef struct packed {
    logic [63:0]      index;
    logic [6:0]       len;
    logic [15:0][2:0] pulse_count_vector;
    logic [15:0]      cnt_neg;
  } index_rsp_s;
endpackage

/* pulse_index_coder.sv */
// Pulse position and sign indexer for algebraic codebook tracks
`timescale 1ns/10ps
`include "pic_consts.svh"
module pulse_index_coder
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Pulse set from the codebook search
  input  wire logic       req_valid_i,
  input  wire pulse_req_s req_i,
  output logic            req_ready_o,
  // Index toward the bitstream packer
  output logic            rsp_valid_o,
  output index_rsp_s      rsp_o,
  input  wire logic       rsp_ready_i
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} seq_state_e;

  seq_state_e  st_ff, nxt_st;
  logic [3:0]  step_ff, nxt_step;
  logic [63:0] acc_ff, nxt_acc;
  logic [2:0]  ptot_ff, nxt_ptot;
  pulse_req_s  req_ff, nxt_req;
  index_rsp_s  rsp_ff, nxt_rsp;
  logic        ready_ff, nxt_ready;
  logic        valid_ff, nxt_valid;

  logic [63:0] fcount [0:7][0:16];
  logic [12:0] ind_a, ind_b;
  logic [24:0] joint;
  logic [3:0]  pos_e;
  logic [4:0]  lrest_e;
  logic [2:0]  cnt_e, ptot_e, pi_e;
  logic [63:0] snew_e, rem_e;
  logic        neg_e;
  logic [19:0] four_idx;

  // Binomial coefficient, small arguments only
  function automatic logic [12:0] binom(input int n, input int k);
    int r;
    r = 1;
    if (k < 0 || n < 0 || k > n) return 13'h0000;
    for (int j = 1; j <= 3; j++)
      if (j <= k) r = (r * (n - j + 1)) / j;
    return 13'(r);
  endfunction

  // Offset of all states with fewer pulses at the head position
  function automatic logic [63:0] part_offset(input logic [2:0] pi, input logic [2:0] ptot,
                                              input logic [4:0] lrest);
    logic [63:0] acc;
    acc = 64'h0;
    for (int p1 = 0; p1 < 8; p1++)
      if (p1 < int'(pi) && p1 <= int'(ptot))
        acc = acc + ((p1 == 0) ? fcount[int'(ptot) - p1][lrest]
                               : {fcount[int'(ptot) - p1][lrest][62:0], 1'b0});
    return acc;
  endfunction

  // Index of one three-pulse track on sixteen positions
  function automatic logic [12:0] tri_index(input logic [2:0][3:0] p, input logic [2:0] s);
    logic [3:0] v [3];
    logic       g [3];
    logic [3:0] up [3];
    logic       us [3];
    logic [1:0] pulse_count_vector [3];
    logic [3:0] tv;
    logic       tg;
    int         n;
    int         position_rank_index;
    int         pulse_count_index;
    int         sign_index;
    int         offset_index;
    for (int i = 0; i < 3; i++) begin
      v[i] = p[i];
      g[i] = s[i];
      up[i] = 4'h0;
      us[i] = 1'b0;
      pulse_count_vector[i] = 2'h0;
    end
    // Ascending sort, signs travel with positions
    for (int r = 0; r < 2; r++)
      for (int i = 0; i < 2 - r; i++)
        if (v[i] > v[i + 1]) begin
          tv = v[i];
          v[i] = v[i + 1];
          v[i + 1] = tv;
          tg = g[i];
          g[i] = g[i + 1];
          g[i + 1] = tg;
        end
    // Merge stacked pulses into one position with a count
    n = 0;
    for (int i = 0; i < 3; i++)
      if (n > 0 && v[i] == up[n - 1]) begin
        pulse_count_vector[n - 1] = pulse_count_vector[n - 1] + 2'h1;
      end else begin
        up[n] = v[i];
        us[n] = g[i];
        pulse_count_vector[n] = 2'h1;
        n = n + 1;
      end
    // Rank of the ascending position subset
    position_rank_index = int'(binom(`TRACK_POS, n))
                        - int'(binom(`TRACK_POS - int'(up[0]), n));
    for (int k = 1; k < 3; k++)
      if (k < n)
        position_rank_index = position_rank_index
                            + int'(binom(`TRACK_POS - 1 - int'(up[k - 1]), n - k))
                            - int'(binom(`TRACK_POS - int'(up[k]), n - k));
    // One surplus pulse leaves a choice only with two positions
    pulse_count_index = (n == 2 && pulse_count_vector[1] == 2'h2) ? 1 : 0;
    sign_index = 0;
    for (int k = 0; k < 3; k++)
      if (k < n && us[k]) sign_index = sign_index + (1 << k);
    offset_index = (n == 3) ? int'(`OFF_N3)
                 : (n == 2) ? int'(`OFF_N2) : int'(`OFF_N1);
    return 13'(offset_index + ((pulse_count_index * int'(binom(`TRACK_POS, n))
                               + position_rank_index) << n) + sign_index);
  endfunction

  // Constellation counts, folded to constants
  always_comb begin
    for (int p = 0; p < 8; p++)
      fcount[p][0] = (p == 0) ? 64'h1 : 64'h0;
    for (int l = 1; l <= 16; l++)
      for (int p = 0; p < 8; p++) begin
        fcount[p][l] = 64'h0;
        for (int p1 = 0; p1 <= p; p1++)
          fcount[p][l] = fcount[p][l] + ((p1 == 0) ? fcount[p][l - 1]
                                         : {fcount[p - p1][l - 1][62:0], 1'b0});
      end
  end

  // Fixed-format and joint indices from the held request
  always_comb begin
    for (int k = 0; k < 4; k++)
      four_idx[19 - 5 * k -: 5] = {req_ff.neg[k], req_ff.pos[k][5:2]};
    ind_a = tri_index(req_ff.tri_pos[0], req_ff.tri_neg[0]);
    ind_b = tri_index(req_ff.tri_pos[1], req_ff.tri_neg[1]);
    joint = 25'(ind_a) * 25'(`TRI_RANGE) + 25'(ind_b);
  end

  // One enumerative step per cycle, one position at a time
  always_comb begin
    pos_e = (req_ff.mode == MODE_ENUM_ENC) ? `ENUM_LAST - step_ff : step_ff;
    lrest_e = 5'(`ENUM_LAST - pos_e);
    cnt_e = req_ff.pulse_count_vector[pos_e];
    neg_e = 1'b0;
    pi_e = 3'h0;
    rem_e = 64'h0;
    if (req_ff.mode == MODE_ENUM_ENC) begin
      ptot_e = ptot_ff + cnt_e;
      snew_e = part_offset(cnt_e, ptot_e, lrest_e)
             + {63'h0, (cnt_e != 3'h0) & req_ff.cnt_neg[pos_e]}
             + ((cnt_e != 3'h0) ? {acc_ff[62:0], 1'b0} : acc_ff);
    end else begin
      // Largest head count whose offset does not pass the state
      for (int p1 = 1; p1 < 8; p1++)
        if (p1 <= int'(ptot_ff) && part_offset(3'(p1), ptot_ff, lrest_e) <= acc_ff)
          pi_e = 3'(p1);
      rem_e = acc_ff - part_offset(pi_e, ptot_ff, lrest_e);
      neg_e = (pi_e != 3'h0) & rem_e[0];
      snew_e = (pi_e != 3'h0) ? {1'b0, rem_e[63:1]} : rem_e;
      ptot_e = ptot_ff - pi_e;
    end
  end

  // Handshake sequencer and result assembly
  always_comb begin
    nxt_st = st_ff;
    nxt_step = step_ff;
    nxt_acc = acc_ff;
    nxt_ptot = ptot_ff;
    nxt_req = req_ff;
    nxt_rsp = rsp_ff;
    nxt_ready = ready_ff;
    nxt_valid = valid_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (req_valid_i && ready_ff) begin
          nxt_req = req_i;
          nxt_ready = 1'b0;
          nxt_step = 4'h0;
          nxt_rsp = '0;
          nxt_acc = (req_i.mode == MODE_ENUM_DEC) ? req_i.state : 64'h0;
          nxt_ptot = (req_i.mode == MODE_ENUM_DEC) ? req_i.total : 3'h0;
          nxt_st = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_valid = 1'b1;
        nxt_st = ST_HOLD;
        unique case (req_ff.mode)
          MODE_FOUR: begin
            nxt_rsp.index = {44'h0, four_idx};
            nxt_rsp.len = `LEN_FOUR;
          end
          MODE_DUO: begin
            nxt_rsp.index = {54'h0, four_idx[19:10]};
            nxt_rsp.len = `LEN_DUO;
          end
          MODE_TRI_JOINT: begin
            if (joint < `JOINT_INDEX_THRESHOLD) begin
              nxt_rsp.index = {39'h0, joint};
              nxt_rsp.len = `LEN_SHORT;
            end else begin
              nxt_rsp.index = {39'h0, joint + `JOINT_INDEX_THRESHOLD};
              nxt_rsp.len = `LEN_LONG;
            end
          end
          MODE_ENUM_ENC, MODE_ENUM_DEC: begin
            nxt_acc = snew_e;
            nxt_ptot = ptot_e;
            nxt_step = step_ff + 4'h1;
            nxt_rsp.pulse_count_vector[pos_e] = (req_ff.mode == MODE_ENUM_DEC) ? pi_e : cnt_e;
            nxt_rsp.cnt_neg[pos_e] = (req_ff.mode == MODE_ENUM_DEC) ? neg_e
                                                                     : req_ff.cnt_neg[pos_e];
            nxt_rsp.index = (req_ff.mode == MODE_ENUM_ENC) ? snew_e : req_ff.state;
            nxt_rsp.len = `LEN_ENUM;
            if (step_ff != `ENUM_LAST) begin
              nxt_valid = 1'b0;
              nxt_st = ST_RUN;
            end
          end
          default: nxt_rsp.len = 7'h00;
        endcase
      end
      ST_HOLD: begin
        if (rsp_ready_i) begin
          nxt_valid = 1'b0;
          nxt_ready = 1'b1;
          nxt_st = ST_IDLE;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= ST_IDLE;
      step_ff <= 4'h0;
      acc_ff <= 64'h0;
      ptot_ff <= 3'h0;
      req_ff <= '0;
      rsp_ff <= '0;
      ready_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      step_ff <= nxt_step;
      acc_ff <= nxt_acc;
      ptot_ff <= nxt_ptot;
      req_ff <= nxt_req;
      rsp_ff <= nxt_rsp;
      ready_ff <= nxt_ready;
      valid_ff <= nxt_valid;
    end
  end

  assign req_ready_o = ready_ff;
  assign rsp_valid_o = valid_ff;
  assign rsp_o = rsp_ff;

  property p_short_below_limit;
    @(posedge clk_i) disable iff (sys_rst_i)
    (rsp_valid_o && rsp_o.len == `LEN_SHORT) |-> rsp_o.index < 64'(`JOINT_INDEX_THRESHOLD);
  endproperty
  a_short_below_limit: assert property (p_short_below_limit)
    else $error("short joint over threshold");

  property p_long_above_limit;
    @(posedge clk_i) disable iff (sys_rst_i)
    (rsp_valid_o && rsp_o.len == `LEN_LONG) |-> rsp_o.index >= 64'(`JOINT_INDEX_THRESHOLD) * 2;
  endproperty
  a_long_above_limit: assert property (p_long_above_limit)
    else $error("long joint not offset");

  property p_joint_range;
    @(posedge clk_i) disable iff (sys_rst_i)
    req_ff.mode == MODE_TRI_JOINT |-> ind_a < `TRI_RANGE && ind_b < `TRI_RANGE;
  endproperty
  a_joint_range: assert property (p_joint_range)
    else $error("track index out of range");

  property p_four_layout;
    @(posedge clk_i) disable iff (sys_rst_i)
    ($rose(rsp_valid_o) && req_ff.mode == MODE_FOUR) |->
      rsp_o.len == `LEN_FOUR && rsp_o.index[4:0] == {req_ff.neg[3], req_ff.pos[3][5:2]};
  endproperty
  a_four_layout: assert property (p_four_layout)
    else $error("four-track layout wrong");

  property p_duo_len;
    @(posedge clk_i) disable iff (sys_rst_i)
    ($rose(rsp_valid_o) && req_ff.mode == MODE_DUO) |-> rsp_o.len == `LEN_DUO;
  endproperty
  a_duo_len: assert property (p_duo_len)
    else $error("two-pulse track length wrong");

  property p_enum_latency;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_valid_i && req_ready_o && req_i.mode inside {MODE_ENUM_ENC, MODE_ENUM_DEC}) |->
      ##16 !rsp_valid_o ##1 rsp_valid_o;
  endproperty
  a_enum_latency: assert property (p_enum_latency)
    else $error("enumerative latency wrong");

  property p_dec_empty_sign;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff == ST_RUN && req_ff.mode == MODE_ENUM_DEC && pi_e == 3'h0) |=>
      !rsp_o.cnt_neg[$past(pos_e)];
  endproperty
  a_dec_empty_sign: assert property (p_dec_empty_sign)
    else $error("sign on empty position");

  property p_hold_stable;
    @(posedge clk_i) disable iff (sys_rst_i)
    (rsp_valid_o && !rsp_ready_i) |=> rsp_valid_o && $stable(rsp_o);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("answer dropped before taken");

  property p_one_side;
    @(posedge clk_i) disable iff (sys_rst_i)
    !(req_ready_o && rsp_valid_o);
  endproperty
  a_one_side: assert property (p_one_side)
    else $error("ready while answer pending");
endmodule

/* pic_search_model.sv */
// Codebook search stand-in that offers pulse sets to the coder
`timescale 1ns/10ps
module pic_search_model
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  // Request toward the coder
  input  wire logic  req_ready_i,
  output logic       req_valid_o,
  output pulse_req_s req_o
);
  // Idle request lines carry a scrambled pattern, never a stale request
  initial begin
    req_valid_o = 1'b0;
    req_o = '1;
  end

  // Offer one pulse set after a gap and hold it until the coder takes it or 100 cycles pass
  task automatic send(input pulse_req_s r, input int gap);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge clk_i);
    // Never offer a pulse set while the coder is held in reset
    while (sys_rst_i !== 1'b0) @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o <= r;
    @(negedge clk_i);
    while (req_ready_i !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_o <= ~r;
  endtask
endmodule

/* algebraic_pulse_index_coder_tb.sv */
// Self-checking bench for the pulse index coder
`timescale 1ns/10ps
module algebraic_pulse_index_coder_tb
  import pic_pkg::*;
;
  localparam longint unsigned TRI_W = 64'h1560;
  localparam longint unsigned JOINT_LIMIT = 64'h371C00;

  logic       clk_i;
  logic       sys_rst_i;
  logic       req_valid_i;
  pulse_req_s req_i;
  logic       req_ready_o;
  logic       rsp_valid_o;
  index_rsp_s rsp_o;
  logic       rsp_ready_i;
  index_rsp_s got;
  int         bad_count;
  int         samples_checked;

  // Coder under test and the search-side model
  pulse_index_coder dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .rsp_ready_i(rsp_ready_i));
  pic_search_model src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_ready_i(req_ready_o),
    .req_valid_o(req_valid_i), .req_o(req_i));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] act);
    samples_checked++;
    if (act !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, act);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Constellation count with a one-position first partition
  function automatic longint unsigned fcnt(input int p, input int l);
    longint unsigned s;
    s = 0;
    if (p == 0) return 1;
    if (l == 1) return 2;
    for (int q = 0; q <= p; q++) s += fcnt(q, 1) * fcnt(p - q, l - 1);
    return s;
  endfunction

  // Enumerative state from position k onward holding p pulses
  function automatic longint unsigned enc(input logic [15:0][2:0] c, input logic [15:0] ng,
                                          input int k, input int p);
    longint unsigned s;
    int n;
    n = int'(c[k]);
    s = (n > 0 && ng[k]) ? 1 : 0;
    if (k == 15) return s;
    for (int q = 0; q < n; q++) s += fcnt(q, 1) * fcnt(p - q, 15 - k);
    return s + fcnt(n, 1) * enc(c, ng, k + 1, p - n);
  endfunction

  // One request, answer latency, answer held under stall, then idle again
  task automatic xfer(input pulse_req_s r, input int lat, input int stall);
    index_rsp_s hold;
    int n;
    n = 0;
    src.send(r, stall);
    do begin
      @(negedge clk_i);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 40);
    if (lat > 0) chk("latency", 64'(lat), 64'(n));
    hold = rsp_o;
    repeat (stall) begin
      @(negedge clk_i);
      chk("held index", hold.index, rsp_o.index);
    end
    @(posedge clk_i);
    rsp_ready_i <= 1'b1;
    @(posedge clk_i);
    rsp_ready_i <= 1'b0;
    @(negedge clk_i);
    chk("idle after answer", 64'h3, {62'h0, req_ready_o, !rsp_valid_o});
    got = hold;
  endtask

  task automatic t_reset();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("reset state", 64'h2, {62'h0, req_ready_o, rsp_valid_o});
    chk("reset answer", 64'h0, rsp_o.index);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask

  task automatic t_four();
    pulse_req_s r;
    logic [19:0] e;
    for (int k = 0; k < 2; k++) begin
      r = '0;
      r.mode = MODE_FOUR;
      r.pos = k ? {6'h03, 6'h3A, 6'h05, 6'h3C} : {6'h3F, 6'h02, 6'h3D, 6'h00};
      r.neg = k ? 4'h5 : 4'hA;
      e = {r.neg[0], r.pos[0][5:2], r.neg[1], r.pos[1][5:2],
           r.neg[2], r.pos[2][5:2], r.neg[3], r.pos[3][5:2]};
      xfer(r, 2, k);
      chk("four index", 64'(e), 64'(got.index[19:0]));
      chk("four len", 64'h14, 64'(got.len));
    end
  endtask

  task automatic t_duo();
    pulse_req_s r;
    r = '0;
    r.mode = MODE_DUO;
    r.pos[0] = 6'h08;
    r.pos[1] = 6'h3C;
    r.neg = 4'h1;
    xfer(r, 2, 3);
    chk("duo index", 64'h24F, 64'(got.index[9:0]));
    chk("duo len", 64'h0A, 64'(got.len));
  endtask

  // Two three-pulse tracks with their expected track indices
  task automatic tri_case(input logic [11:0] pa, input logic [2:0] na, input logic [11:0] pb,
                          input logic [2:0] nb, input longint unsigned ia,
                          input longint unsigned ib);
    pulse_req_s r;
    longint unsigned j;
    r = '0;
    r.mode = MODE_TRI_JOINT;
    r.tri_pos = {pb, pa};
    r.tri_neg = {nb, na};
    j = ia * TRI_W + ib;
    xfer(r, 2, 0);
    if (j < JOINT_LIMIT) begin
      chk("joint index", j, 64'(got.index[24:0]));
      chk("joint len", 64'h18, 64'(got.len));
    end else begin
      chk("joint index", j + JOINT_LIMIT, 64'(got.index[24:0]));
      chk("joint len", 64'h19, 64'(got.len));
    end
  endtask

  // Threshold edges, merged and unsorted pulses, one to three occupied positions
  task automatic t_tri();
    tri_case(12'hE80, 3'h4, 12'h420, 3'h7, 64'h294, 64'h7F);
    tri_case(12'hE80, 3'h4, 12'h520, 3'h0, 64'h294, 64'h80);
    tri_case(12'h335, 3'h6, 12'h535, 3'h5, 64'h122D, 64'h140E);
    tri_case(12'h333, 3'h7, 12'h102, 3'h1, 64'h1547, 64'h4);
  endtask

  task automatic t_enum();
    pulse_req_s r;
    logic [15:0][2:0] v;
    logic [15:0] ng;
    longint unsigned st;
    v = '0;
    v[0] = 3'h2;
    v[7] = 3'h3;
    v[9] = 3'h1;
    v[15] = 3'h1;
    ng = 16'h0281;
    st = enc(v, ng, 0, 7);
    r = '0;
    r.mode = MODE_ENUM_ENC;
    r.pulse_count_vector = v;
    r.cnt_neg = ng;
    r.total = 3'h7;
    xfer(r, 17, 1);
    chk("enum state", st, got.index);
    chk("enum len", 64'h40, 64'(got.len));
    r = '0;
    r.mode = MODE_ENUM_DEC;
    r.total = 3'h7;
    r.state = st;
    xfer(r, 17, 0);
    chk("decoded counts", 64'(v), 64'(got.pulse_count_vector));
    chk("decoded signs", 64'(ng), 64'(got.cnt_neg));
    chk("decoded echo", st, got.index);
  endtask

  // Unknown mode codes, then a reset while an answer is pending
  task automatic t_odd();
    pulse_req_s r;
    r = '0;
    for (int m = 5; m < 8; m++) begin
      r.mode = op_mode_e'(3'(m));
      xfer(r, 2, 0);
      chk("unknown mode len", 64'h0, 64'(got.len));
    end
    r.mode = MODE_FOUR;
    src.send(r, 0);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) begin
      @(negedge clk_i);
      chk("abort idle", 64'h3, {62'h0, req_ready_o, !rsp_valid_o});
    end
  endtask

  // Main sequence
  initial begin
    bad_count = 0;
    samples_checked = 0;
    sys_rst_i = 1'b1;
    rsp_ready_i = 1'b0;
    t_reset();
    t_four();
    t_duo();
    t_tri();
    t_enum();
    t_odd();
    t_four();
    give_verdict();
  end

  // Watchdog cuts a hang short
  initial begin
    #(20 * 3000);
    bad_count++;
    give_verdict();
  end
endmodule
